// >>> inc/hps_map.svh
// offsets, field positions, reset values and timing counts of the port
// Overview of operation
// (R1) control pin polarity set by configuration
// (R2) reads use read strobe or shared strobe
// (R3) writes use write strobe or shared strobe
// (R4) one combined request or separate rx/tx
// (R5) completing data register sits at address 7
// (R6) big endian: low byte completes the word
// (R7) little endian: high byte completes the word
// (R8) byte order select is control bit 7
// (R9) port usable three cycles after control write
// (R10) receive word read as three byte registers
// (R11) host paces reads on flag or request
// (R12) request output may be open drain
// (R13) multiplexed and plain bus, both strobe modes
// (R14) open drain select 1 releases high level
// (R15) completing access drops its request
// (R16) other byte accesses only move bytes
`ifndef HPS_MAP_SVH
`define HPS_MAP_SVH
// port addresses seen by the host
`define HPS_A_CTL      3'h0
`define HPS_A_ISR      3'h2
`define HPS_A_VEC      3'h3
`define HPS_A_FIRST    3'h5
`define HPS_A_MID      3'h6
`define HPS_A_LAST     3'h7
// interface control register fields
`define HPS_CTL_RXEN   0
`define HPS_CTL_TXEN   1
`define HPS_CTL_BORD   7
`define HPS_CTL_RST    8'h00
// port status register fields
`define HPS_ISR_RXF    0
`define HPS_ISR_TXE    1
// vector register reset value, arbitrary
`define HPS_VEC_RST    8'h0f
// device cycles before the port is usable after a control write
`define HPS_SETTLE_CYC 3
// host pin timing in clock cycles
`define HPS_SYNC_CYC   2
`define HPS_SETUP_CYC  2
`define HPS_STB_CYC    8
`define HPS_REC_CYC    4
// host controller APB offsets
`define HPS_R_CMD      8'h00
`define HPS_R_CFG      8'h04
`define HPS_R_STAT     8'h08
`define HPS_R_ISR      8'h0c
`define HPS_R_IMR      8'h10
// command register fields
`define HPS_CMD_ADR_LO 8
`define HPS_CMD_RD     16
// host configuration fields
`define HPS_CFG_POLHI  0
`define HPS_CFG_DUAL   1
`define HPS_CFG_MUX    2
`define HPS_CFG_DBLREQ 3
`define HPS_CFG_RST    4'h0
// host status and event fields
`define HPS_STAT_BUSY  8
`define HPS_STAT_RXRQ  9
`define HPS_STAT_TXRQ  10
`define HPS_EV_DONE    0
`define HPS_EV_REQ     1
`endif

// >>> inc/hps_pkg.sv
// types shared by both ends of the host port
`default_nettype none
package hps_pkg;
    typedef logic [7:0]  hps_byte_t;
    typedef logic [31:0] hps_word_t;
    typedef enum logic [2:0] {
        HPS_ST_IDLE = 3'b000,
        HPS_ST_ADR  = 3'b001,
        HPS_ST_SET  = 3'b010,
        HPS_ST_STB  = 3'b011,
        HPS_ST_REC  = 3'b100,
        HPS_ST_SETL = 3'b101
    } hps_st_t;
endpackage
`default_nettype wire

// >>> inc/hps_if.sv
// pins between host and device, with resolved bus levels
`default_nettype none
interface hps_if;
    import hps_pkg::*;
    logic      addr_strobe;
    logic      shared_data_strobe;
    logic      read_strobe;
    logic      write_strobe;
    logic      read_not_write;
    logic [2:0] addr;
    hps_byte_t h_dat_o;
    logic      h_dat_oe;
    hps_byte_t d_dat_o;
    logic      d_dat_oe;
    logic      combined_request_o;
    logic      combined_request_oe;
    logic      receive_request_o;
    logic      receive_request_oe;
    logic      transmit_request_o;
    logic      transmit_request_oe;
    hps_byte_t dat;
    logic      combined_request;
    logic      receive_request;
    logic      transmit_request;
    // undriven lines float high through pull-ups
    assign dat = d_dat_oe ? d_dat_o : (h_dat_oe ? h_dat_o : 8'hff);
    assign combined_request = combined_request_oe ? combined_request_o
                                                  : 1'b1;
    assign receive_request  = receive_request_oe ? receive_request_o
                                                 : 1'b1;
    assign transmit_request = transmit_request_oe ? transmit_request_o
                                                  : 1'b1;
    modport dev (
        input  addr_strobe, shared_data_strobe, read_strobe,
        input  write_strobe, read_not_write, addr, dat,
        output d_dat_o, d_dat_oe,
        output combined_request_o, combined_request_oe,
        output receive_request_o, receive_request_oe,
        output transmit_request_o, transmit_request_oe
    );
    modport hst (
        output addr_strobe, shared_data_strobe, read_strobe,
        output write_strobe, read_not_write, addr, h_dat_o, h_dat_oe,
        input  dat, combined_request, receive_request, transmit_request
    );
endinterface
`default_nettype wire

// >>> src/hps_sync.sv
// two-stage synchroniser for a bundle of pin levels
`default_nettype none
module hps_sync #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_nrst,
    // levels
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            // ones: idle level of pulled-up, low-active lines,
            // so no false strobe or request edge follows reset
            meta_r <= '1;
            o_q    <= '1;
        end else begin
            meta_r <= i_d;
            o_q    <= meta_r;
        end
    end
endmodule
`default_nettype wire

// >>> src/hps_dev.sv
// device end of the parallel host port
`default_nettype none
`include "hps_map.svh"
module hps_dev (
    // clock and reset
    input  wire logic        I_CLK,
    input  wire logic        I_NRST,
    // pins toward the host
    hps_if.dev               PORT,
    // configuration from the core
    input  wire logic        I_CFG_POL_HIGH,
    input  wire logic        I_CFG_DUAL_STB,
    input  wire logic        I_CFG_MUX,
    input  wire logic        I_CFG_DBL_REQ,
    input  wire logic        I_CFG_OPEN_DRAIN,
    // words from the core toward the host
    input  wire logic [23:0] I_RX_WORD,
    input  wire logic        I_RX_VALID,
    output logic             O_RX_READY,
    // words from the host toward the core
    output logic [23:0]      O_TX_WORD,
    output logic             O_TX_VALID,
    input  wire logic        I_TX_READY,
    // status
    output logic             O_BYTE_ORDER,
    output logic             O_READY
);
    import hps_pkg::*;

    logic [15:0] pin_s;
    logic        inv;
    logic        as_a;
    logic        rd_a;
    logic        wr_a;
    logic        as_q_r;
    logic        rd_q_r;
    logic        wr_q_r;
    logic        as_go;
    logic        rd_go;
    logic        wr_go;
    logic [2:0]  adr_s;
    logic [2:0]  mux_adr_r;
    logic [2:0]  cur_adr;
    hps_byte_t   dat_s;
    hps_byte_t   interface_control_register_r;
    logic [1:0]  settle_r;
    logic        busy;
    logic        bord;
    logic        sel_hi;
    logic        sel_lo;
    logic        last;
    hps_byte_t   rx_high_byte_r;
    hps_byte_t   rx_mid_byte_r;
    hps_byte_t   rx_low_byte_r;
    hps_byte_t   tx_high_byte_r;
    hps_byte_t   tx_mid_byte_r;
    hps_byte_t   tx_low_byte_r;
    logic        rx_full_flag_r;
    logic        tx_full_r;
    hps_byte_t   rd_mux;
    hps_byte_t   rdata_r;
    logic        dat_oe_r;
    logic [2:0]  req_act;
    logic [2:0]  req_en;
    logic [2:0]  lvl_r;
    logic [2:0]  en_r;
    logic [2:0]  req_o;
    logic [2:0]  req_oe;

    // every pin passes two flops before use
    hps_sync #(.W(16)) u_sync (
        .i_clk (I_CLK),
        .i_nrst(I_NRST),
        .i_d   ({PORT.addr_strobe, PORT.shared_data_strobe,
                 PORT.read_strobe, PORT.write_strobe,
                 PORT.read_not_write, PORT.addr, PORT.dat}),
        .o_q   (pin_s)
    );

    // (R1) programmable pin polarity
    assign inv   = ~I_CFG_POL_HIGH;
    assign as_a  = pin_s[15] ^ inv;
    assign adr_s = pin_s[10:8];
    assign dat_s = pin_s[7:0];
    // (R2) read strobe selection
    assign rd_a = I_CFG_DUAL_STB ? (pin_s[13] ^ inv)
                                 : ((pin_s[14] ^ inv) & pin_s[11]);
    // (R3) write strobe selection
    assign wr_a = I_CFG_DUAL_STB ? (pin_s[12] ^ inv)
                                 : ((pin_s[14] ^ inv) & ~pin_s[11]);

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            as_q_r <= 1'b0;
            rd_q_r <= 1'b0;
            wr_q_r <= 1'b0;
        end else begin
            as_q_r <= as_a;
            rd_q_r <= rd_a;
            wr_q_r <= wr_a;
        end
    end

    // (R9) accesses ignored while settling
    assign busy  = (settle_r != 2'd0);
    assign as_go = as_a & ~as_q_r;
    assign rd_go = rd_a & ~rd_q_r & ~busy;
    assign wr_go = wr_a & ~wr_q_r & ~busy;

    // (R13) multiplexed address latch
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            mux_adr_r <= 3'h0;
        end else if (as_go) begin
            mux_adr_r <= dat_s[2:0];
        end
    end
    assign cur_adr = I_CFG_MUX ? mux_adr_r : adr_s;

    // (R8) byte order bit position
    assign bord = interface_control_register_r[`HPS_CTL_BORD];
    // (R5) completing register address
    assign last = (cur_adr == `HPS_A_LAST);
    // (R6) big endian completes on low
    // (R7) little endian completes on high
    assign sel_hi = (cur_adr == `HPS_A_FIRST & ~bord) | (last & bord);
    assign sel_lo = (cur_adr == `HPS_A_FIRST & bord) | (last & ~bord);

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            interface_control_register_r <= `HPS_CTL_RST;
        end else if (wr_go && cur_adr == `HPS_A_CTL) begin
            interface_control_register_r <= dat_s;
        end
    end

    // (R9) three cycle settle count
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            settle_r <= 2'd0;
        end else if (wr_go && cur_adr == `HPS_A_CTL) begin
            settle_r <= 2'(`HPS_SETTLE_CYC);
        end else if (busy) begin
            settle_r <= settle_r - 2'd1;
        end
    end

    // receive word loads only when empty, so load and clear never meet
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            rx_high_byte_r <= 8'h00;
            rx_mid_byte_r  <= 8'h00;
            rx_low_byte_r  <= 8'h00;
        end else if (I_RX_VALID && !rx_full_flag_r) begin
            rx_high_byte_r <= I_RX_WORD[23:16];
            rx_mid_byte_r  <= I_RX_WORD[15:8];
            rx_low_byte_r  <= I_RX_WORD[7:0];
        end
    end

    // (R15) completing read clears full flag
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            rx_full_flag_r <= 1'b0;
        end else if (I_RX_VALID && !rx_full_flag_r) begin
            rx_full_flag_r <= 1'b1;
        end else if (rd_go && last) begin
            rx_full_flag_r <= 1'b0;
        end
    end
    assign O_RX_READY = ~rx_full_flag_r;

    // (R16) non-completing bytes only stored
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            tx_high_byte_r <= 8'h00;
            tx_mid_byte_r  <= 8'h00;
            tx_low_byte_r  <= 8'h00;
        end else if (wr_go) begin
            if (sel_hi) begin
                tx_high_byte_r <= dat_s;
            end
            if (cur_adr == `HPS_A_MID) begin
                tx_mid_byte_r <= dat_s;
            end
            if (sel_lo) begin
                tx_low_byte_r <= dat_s;
            end
        end
    end

    // (R15) completing write fills the word
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            tx_full_r <= 1'b0;
        end else if (wr_go && last) begin
            tx_full_r <= 1'b1;
        end else if (I_TX_READY) begin
            tx_full_r <= 1'b0;
        end
    end
    assign O_TX_VALID = tx_full_r;
    assign O_TX_WORD  = {tx_high_byte_r, tx_mid_byte_r, tx_low_byte_r};

    // (R10) three receive byte registers
    always_comb begin
        rd_mux = 8'h00;
        case (cur_adr)
            `HPS_A_CTL: rd_mux = interface_control_register_r;
            `HPS_A_ISR: begin
                rd_mux[`HPS_ISR_RXF] = rx_full_flag_r;
                rd_mux[`HPS_ISR_TXE] = ~tx_full_r;
            end
            `HPS_A_VEC: rd_mux = `HPS_VEC_RST;
            `HPS_A_FIRST,
            `HPS_A_LAST: rd_mux = sel_hi ? rx_high_byte_r : rx_low_byte_r;
            `HPS_A_MID: rd_mux = rx_mid_byte_r;
            default: rd_mux = 8'h00;
        endcase
    end

    // bus driven only while the read strobe stands
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            rdata_r  <= 8'h00;
            dat_oe_r <= 1'b0;
        end else begin
            rdata_r  <= rd_mux;
            dat_oe_r <= rd_a & ~busy;
        end
    end
    assign PORT.d_dat_o  = rdata_r;
    assign PORT.d_dat_oe = dat_oe_r;

    // (R4) single or double request pins
    assign req_act[0] =
        (rx_full_flag_r & interface_control_register_r[`HPS_CTL_RXEN]) |
        (~tx_full_r & interface_control_register_r[`HPS_CTL_TXEN]);
    assign req_act[1] =
        rx_full_flag_r & interface_control_register_r[`HPS_CTL_RXEN];
    assign req_act[2] =
        ~tx_full_r & interface_control_register_r[`HPS_CTL_TXEN];
    assign req_en = I_CFG_DBL_REQ ? 3'b110 : 3'b001;

    for (genvar g = 0; g < 3; g++) begin : g_req
        always_ff @(posedge I_CLK or negedge I_NRST) begin
            if (!I_NRST) begin
                lvl_r[g] <= 1'b1;
                en_r[g]  <= 1'b0;
            end else begin
                lvl_r[g] <= req_act[g] ^ inv;
                en_r[g]  <= req_en[g];
            end
        end
        // (R12) open drain only pulls low
        // (R14) open drain select releases highs
        assign req_o[g]  = I_CFG_OPEN_DRAIN ? 1'b0 : lvl_r[g];
        assign req_oe[g] = en_r[g] & (~I_CFG_OPEN_DRAIN | ~lvl_r[g]);
    end

    assign PORT.combined_request_o  = req_o[0];
    assign PORT.combined_request_oe = req_oe[0];
    assign PORT.receive_request_o   = req_o[1];
    assign PORT.receive_request_oe  = req_oe[1];
    assign PORT.transmit_request_o  = req_o[2];
    assign PORT.transmit_request_oe = req_oe[2];

    assign O_BYTE_ORDER = bord;
    assign O_READY      = ~busy;
endmodule
`default_nettype wire

// >>> src/hps_hst.sv
// host end of the parallel host port, ordered over APB
`default_nettype none
`include "hps_map.svh"
module hps_hst (
    // clock and reset
    input  wire logic              I_CLK,
    input  wire logic              I_NRST,
    // APB slave
    input  wire logic              I_PSEL,
    input  wire logic              I_PENABLE,
    input  wire logic              I_PWRITE,
    input  wire logic [7:0]        I_PADDR,
    input  wire hps_pkg::hps_word_t I_PWDATA,
    output hps_pkg::hps_word_t     O_PRDATA,
    output logic                   O_PREADY,
    output logic                   O_PSLVERR,
    // interrupt
    output logic                   O_IRQ,
    // pins toward the device
    hps_if.hst                     PORT
);
    import hps_pkg::*;

    hps_st_t    st_r;
    logic [3:0] cnt_r;
    logic [3:0] cfg_r;
    logic [2:0] adr_r;
    hps_byte_t  wdat_r;
    logic       rd_r;
    hps_byte_t  rdata_r;
    logic [1:0] isr_r;
    logic [1:0] imr_r;
    logic [1:0] ev;
    logic       wr_acc;
    logic       go;
    logic       inv;
    logic       cnt_end;
    logic [10:0] pin_s;
    logic       rxrq;
    logic       txrq;
    logic       req_q_r;

    assign wr_acc  = I_PSEL & I_PENABLE & I_PWRITE;
    assign go      = wr_acc & (I_PADDR == `HPS_R_CMD) &
                     (st_r == HPS_ST_IDLE);
    assign inv     = ~cfg_r[`HPS_CFG_POLHI];
    assign cnt_end = (cnt_r == 4'd0);

    hps_sync #(.W(11)) u_sync (
        .i_clk (I_CLK),
        .i_nrst(I_NRST),
        .i_d   ({PORT.combined_request, PORT.receive_request,
                 PORT.transmit_request, PORT.dat}),
        .o_q   (pin_s)
    );

    // (R4) request sensing per mode
    assign rxrq = cfg_r[`HPS_CFG_DBLREQ] ? (pin_s[9] ^ inv)
                                         : (pin_s[10] ^ inv);
    assign txrq = cfg_r[`HPS_CFG_DBLREQ] ? (pin_s[8] ^ inv)
                                         : (pin_s[10] ^ inv);

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            cfg_r <= `HPS_CFG_RST;
            imr_r <= 2'b00;
        end else if (wr_acc) begin
            if (I_PADDR == `HPS_R_CFG) begin
                cfg_r <= I_PWDATA[3:0];
            end
            if (I_PADDR == `HPS_R_IMR) begin
                imr_r <= I_PWDATA[1:0];
            end
        end
    end

    // commands written while busy are dropped
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            adr_r  <= 3'h0;
            wdat_r <= 8'h00;
            rd_r   <= 1'b0;
        end else if (go) begin
            wdat_r <= I_PWDATA[7:0];
            adr_r  <= I_PWDATA[`HPS_CMD_ADR_LO +: 3];
            rd_r   <= I_PWDATA[`HPS_CMD_RD];
        end
    end

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            st_r  <= HPS_ST_IDLE;
            cnt_r <= 4'd0;
        end else begin
            case (st_r)
                HPS_ST_IDLE: begin
                    if (go && cfg_r[`HPS_CFG_MUX]) begin
                        st_r  <= HPS_ST_ADR;
                        cnt_r <= 4'(`HPS_STB_CYC - 1);
                    end else if (go) begin
                        st_r  <= HPS_ST_SET;
                        cnt_r <= 4'(`HPS_SETUP_CYC - 1);
                    end
                end
                // (R13) address phase on multiplexed bus
                HPS_ST_ADR: begin
                    cnt_r <= cnt_r - 4'd1;
                    if (cnt_end) begin
                        st_r  <= HPS_ST_SET;
                        cnt_r <= 4'(`HPS_SETUP_CYC - 1);
                    end
                end
                HPS_ST_SET: begin
                    cnt_r <= cnt_r - 4'd1;
                    if (cnt_end) begin
                        st_r  <= HPS_ST_STB;
                        cnt_r <= 4'(`HPS_STB_CYC - 1);
                    end
                end
                HPS_ST_STB: begin
                    cnt_r <= cnt_r - 4'd1;
                    if (cnt_end) begin
                        st_r  <= HPS_ST_REC;
                        cnt_r <= 4'(`HPS_REC_CYC - 1);
                    end
                end
                // (R9) host waits out the settle time
                HPS_ST_REC: begin
                    cnt_r <= cnt_r - 4'd1;
                    if (cnt_end && !rd_r && adr_r == `HPS_A_CTL) begin
                        st_r  <= HPS_ST_SETL;
                        cnt_r <= 4'(`HPS_SETTLE_CYC + `HPS_SYNC_CYC);
                    end else if (cnt_end) begin
                        st_r <= HPS_ST_IDLE;
                    end
                end
                HPS_ST_SETL: begin
                    cnt_r <= cnt_r - 4'd1;
                    if (cnt_end) begin
                        st_r <= HPS_ST_IDLE;
                    end
                end
                default: st_r <= HPS_ST_IDLE;
            endcase
        end
    end

    // read data taken on the strobe's last cycle
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            rdata_r <= 8'h00;
        end else if (st_r == HPS_ST_STB && cnt_end && rd_r) begin
            rdata_r <= pin_s[7:0];
        end
    end

    // (R1) host drives the chosen polarity
    assign PORT.addr_strobe    = (st_r == HPS_ST_ADR) ^ inv;
    assign PORT.read_not_write = rd_r;
    assign PORT.addr           = adr_r;
    // (R2) read on its configured strobe
    // (R3) write on its configured strobe
    assign PORT.shared_data_strobe =
        ((st_r == HPS_ST_STB) & ~cfg_r[`HPS_CFG_DUAL]) ^ inv;
    assign PORT.read_strobe =
        ((st_r == HPS_ST_STB) & cfg_r[`HPS_CFG_DUAL] & rd_r) ^ inv;
    assign PORT.write_strobe =
        ((st_r == HPS_ST_STB) & cfg_r[`HPS_CFG_DUAL] & ~rd_r) ^ inv;
    assign PORT.h_dat_o  = (st_r == HPS_ST_ADR) ? {5'h00, adr_r} : wdat_r;
    assign PORT.h_dat_oe = (st_r == HPS_ST_ADR) |
        (~rd_r & (st_r == HPS_ST_SET || st_r == HPS_ST_STB));

    // (R11) receive or combined request rise raises an event
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            req_q_r <= 1'b0;
        end else begin
            req_q_r <= rxrq;
        end
    end
    assign ev[`HPS_EV_DONE] = (st_r == HPS_ST_REC && cnt_end &&
                               !(!rd_r && adr_r == `HPS_A_CTL)) ||
                              (st_r == HPS_ST_SETL && cnt_end);
    assign ev[`HPS_EV_REQ]  = rxrq & ~req_q_r;

    // an event in the clearing cycle survives
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            isr_r <= 2'b00;
        end else if (wr_acc && I_PADDR == `HPS_R_ISR) begin
            isr_r <= (isr_r & ~I_PWDATA[1:0]) | ev;
        end else begin
            isr_r <= isr_r | ev;
        end
    end
    assign O_IRQ = |(isr_r & imr_r);

    // read data registered in the setup cycle
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            O_PRDATA <= 32'h0000_0000;
        end else if (I_PSEL && !I_PENABLE) begin
            O_PRDATA <= 32'h0000_0000;
            case (I_PADDR)
                `HPS_R_CMD: O_PRDATA <= {15'h0000, rd_r, 5'h00, adr_r,
                                         wdat_r};
                `HPS_R_CFG: O_PRDATA <= {28'h0000000, cfg_r};
                `HPS_R_STAT: O_PRDATA <= {21'h000000, txrq, rxrq,
                                          (st_r != HPS_ST_IDLE), rdata_r};
                `HPS_R_ISR: O_PRDATA <= {30'h00000000, isr_r};
                `HPS_R_IMR: O_PRDATA <= {30'h00000000, imr_r};
                default: O_PRDATA <= 32'h0000_0000;
            endcase
        end
    end
    assign O_PREADY  = 1'b1;
    assign O_PSLVERR = 1'b0;
endmodule
`default_nettype wire

// >>> testbench/hps_assertions.sv
// pin-level checks of the host port link
`default_nettype none
module hps_assertions (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_NRST,
    // link pins
    input wire logic shared_data_strobe,
    input wire logic read_strobe,
    input wire logic write_strobe,
    input wire logic h_dat_oe,
    input wire logic d_dat_oe
);
    default clocking @(posedge I_CLK);
    endclocking
    default disable iff (!I_NRST);
    sequence s_held(x);
        $stable(x)[*3];
    endsequence
    fight_a: assert property (!(d_dat_oe && h_dat_oe))
        else $error("data bus driven by both ends");
    rd_hold_a: assert property ($changed(read_strobe) |=>
        s_held(read_strobe)) else $error("read strobe too short");
    wr_hold_a: assert property ($changed(write_strobe) |=>
        s_held(write_strobe)) else $error("write strobe too short");
    ds_hold_a: assert property ($changed(shared_data_strobe) |=>
        s_held(shared_data_strobe)) else $error("strobe too short");
    wr_setup_a: assert property ($rose(h_dat_oe) |=>
        $stable(write_strobe) && $stable(shared_data_strobe))
        else $error("write data not set up");
    wr_keep_a: assert property ($rose(h_dat_oe) |=> h_dat_oe[*6])
        else $error("write data dropped early");
    wr_free_a: assert property (h_dat_oe |-> ##[1:30] !h_dat_oe)
        else $error("write data never released");
    rd_free_a: assert property (d_dat_oe |-> ##[1:16] !d_dat_oe)
        else $error("read data never released");
endmodule
`default_nettype wire

// >>> testbench/tb_hps.sv
// bench joining the two ends of the host port
`default_nettype none
module tb_hps;
    timeunit 1ns;
    timeprecision 1ps;
    import hps_pkg::*;
    logic        clk, nrst, psel, pen, pwr, rxv, txr;
    logic        prdy, perr, irq, rxr, txv, bo, rdy, e;
    logic [7:0]  pa;
    logic [4:0]  c;
    logic [23:0] rxw, txw;
    hps_word_t   pwd, prd, q;
    int          failures, comparisons;
    hps_if i_hps_if ();
    wire logic   rq = c[3] ? i_hps_if.receive_request
                           : i_hps_if.combined_request;
    hps_dev i_hps_dev (.I_CLK(clk), .I_NRST(nrst), .PORT(i_hps_if),
        .I_CFG_POL_HIGH(c[4]), .I_CFG_DUAL_STB(c[1]), .I_CFG_MUX(c[2]),
        .I_CFG_DBL_REQ(c[3]), .I_CFG_OPEN_DRAIN(c[0]), .I_RX_WORD(rxw),
        .I_RX_VALID(rxv), .O_RX_READY(rxr), .O_TX_WORD(txw),
        .O_TX_VALID(txv), .I_TX_READY(txr), .O_BYTE_ORDER(bo), .O_READY(rdy));
    hps_hst i_hps_hst (.I_CLK(clk), .I_NRST(nrst), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(pa), .I_PWDATA(pwd),
        .O_PRDATA(prd), .O_PREADY(prdy), .O_PSLVERR(perr), .O_IRQ(irq),
        .PORT(i_hps_if));
    hps_assertions i_hps_assertions (.I_CLK(clk), .I_NRST(nrst),
        .shared_data_strobe(i_hps_if.shared_data_strobe),
        .read_strobe(i_hps_if.read_strobe),
        .write_strobe(i_hps_if.write_strobe),
        .h_dat_oe(i_hps_if.h_dat_oe), .d_dat_oe(i_hps_if.d_dat_oe));
    task automatic apb(input logic w, input logic [7:0] a, input hps_word_t d);
        {psel, pwr, pa, pwd} <= {1'b1, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (prdy !== 1'b1);
        q = prd;
        {psel, pen} <= 2'b00;
        @(posedge clk);
    endtask
    task automatic chk(input hps_word_t g, input hps_word_t x);
        comparisons++;
        if (g !== x) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    // read commands check their byte, writes send it
    task automatic cmd(input logic r, input logic [2:0] a,
                       input hps_byte_t d);
        apb(1'b1, 8'h00, {15'h0, r, 5'h0, a, d});
        do apb(1'b0, 8'h08, 32'h0); while (q[8] !== 1'b0);
        if (r) chk(q[7:0], d);
    endtask
    task automatic test_done();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial forever #5 clk = ~clk;
    initial begin
        repeat (30000) @(posedge clk);
        failures++;
        test_done();
    end
    initial begin
        {clk, nrst, psel, pen, pwr, rxv, txr, pa, c, rxw, pwd} = '0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        cmd(1'b1, 3'h3, 8'h0f);
        chk({perr, irq}, 2'b00);
        apb(1'b1, 8'h10, 32'h1);
        chk(irq, 1'b1);
        apb(1'b1, 8'h0c, 32'h1);
        apb(1'b0, 8'h14, 32'h0);
        chk({q[30:0], irq}, 32'h0);
        $display("interrupt test done");
        for (int k = 0; k < 32; k++) begin
            e = k[0] ^ k[2];
            c <= k[4:0];
            rxw <= {3'h5, k[4:0], 16'h96c3};
            apb(1'b1, 8'h04, {28'h0, k[3:1], k[4]});
            // polarity flip may fake one access, so drain and reload
            {txr, rxv} <= 2'b11;
            repeat (10) @(posedge clk);
            {txr, rxv} <= 2'b00;
            cmd(1'b0, 3'h0, {e, 7'h01});
            chk(q[10:9], {!c[3], 1'b1});
            chk({bo, rdy, rq}, {e, 1'b1, c[4]});
            cmd(1'b1, 3'h5, e ? rxw[7:0] : rxw[23:16]);
            cmd(1'b1, 3'h6, rxw[15:8]);
            chk({rxr, rq}, {1'b0, c[4]});
            cmd(1'b1, 3'h7, e ? rxw[23:16] : rxw[7:0]);
            chk({rxr, rq}, {1'b1, !c[4]});
            cmd(1'b0, 3'h5, 8'h11);
            cmd(1'b0, 3'h6, 8'h22);
            cmd(1'b0, 3'h7, 8'h33);
            chk({txv, txw}, {1'b1, e ? 24'h332211 : 24'h112233});
            $display("config %0d done", k);
        end
        test_done();
    end
endmodule
`default_nettype wire
